// >>> inc/acs_pkg.sv
package acs_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL_A = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B = 8'h04;
   localparam logic [7:0] ADDR_CH_REF = 8'h08;
   localparam logic [7:0] ADDR_RES_LO = 8'h0C;
   localparam logic [7:0] ADDR_RES_HI = 8'h10;

   // converter_control_a fields
   localparam int CA_ENABLE = 7;
   localparam int CA_START = 6;
   localparam int CA_AUTO = 5;
   localparam int CA_DONE = 4;
   localparam int CA_IRQ_EN = 3;
   localparam int CA_PRESC_LSB = 0;
   // converter_control_b fields
   localparam int CB_LEFT = 4;
   localparam int CB_TRIG_LSB = 0;
   // channel_reference_config fields
   localparam int CR_REF = 6;
   localparam int CR_CHAN_LSB = 0;

   localparam logic [2:0] TRIG_DONE_FLAG = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // conversion timing in half converter clock cycles
   localparam logic [5:0] FIRST_SH_X2 = 6'h1B;   // 13.5 cycles
   localparam logic [5:0] FIRST_LEN_X2 = 6'h32;  // 25 cycles
   localparam logic [5:0] NORM_SH_X2 = 6'h03;    // 1.5 cycles
   localparam logic [5:0] NORM_LEN_X2 = 6'h1A;   // 13 cycles
   localparam logic [5:0] AUTO_SH_X2 = 6'h04;    // 2 cycles
   localparam logic [5:0] AUTO_LEN_X2 = 6'h1B;   // 13.5 cycles
   localparam logic [5:0] FREE_SH_X2 = 6'h05;    // 2.5 cycles
   localparam logic [5:0] FREE_LEN_X2 = 6'h1C;   // 14 cycles
   localparam logic [5:0] LAST_CYCLE_X2 = 6'h02;
   localparam logic [1:0] SYNC_CYCLES = 2'h3;

   localparam logic [1:0] KIND_FIRST = 2'h0;
   localparam logic [1:0] KIND_NORM = 2'h1;
   localparam logic [1:0] KIND_AUTO = 2'h2;
   localparam logic [1:0] KIND_FREE = 2'h3;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_PEND = 4'b0010,
      ST_SYNC = 4'b0100,
      ST_RUN = 4'b1000
   } acs_state_e_t;

   typedef struct packed {
      acs_state_e_t st;
      logic [1:0] kind;
      logic [5:0] ph;
      logic [6:0] div;
      logic [1:0] sync;
      logic en;
      logic auto_en;
      logic done_flag;
      logic irq_en;
      logic [2:0] presc;
      logic [2:0] trig_sel;
      logic left;
      logic [3:0] chan_sw;
      logic ref_sw;
      logic [3:0] chan_lk;
      logic ref_lk;
      logic first;
      logic rd_lock;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic [7:0] trig_q;
      logic sleep_q;
      logic sh_pulse;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [7:0] w_data;
      logic w_lane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } acs_regs_t;

   function automatic logic [6:0] div_mask(input logic [2:0] sel);
      logic [6:0] m;
      m = 7'h01;
      if (sel > 3'h1) begin
         m = 7'(({7'h00, 1'b1} << sel) - 8'h01);
      end
      return m;
   endfunction : div_mask

   function automatic logic [5:0] sh_x2(input logic [1:0] kind);
      unique case (kind)
         KIND_FIRST: return FIRST_SH_X2;
         KIND_NORM: return NORM_SH_X2;
         KIND_AUTO: return AUTO_SH_X2;
         default: return FREE_SH_X2;
      endcase
   endfunction : sh_x2

   function automatic logic [5:0] len_x2(input logic [1:0] kind);
      unique case (kind)
         KIND_FIRST: return FIRST_LEN_X2;
         KIND_NORM: return NORM_LEN_X2;
         KIND_AUTO: return AUTO_LEN_X2;
         default: return FREE_LEN_X2;
      endcase
   endfunction : len_x2

endpackage : acs_pkg

// >>> rtl/acs_sequencer.sv
// Overview of operation
// RL1 - analog selections inactive until converter enabled
// RL2 - result right-aligned, left-aligned when selected
// RL3 - low byte read blocks result updates
// RL4 - high byte read re-enables result updates
// RL5 - done flag set even when result discarded
// RL6 - start flag starts conversion, cleared at end
// RL7 - channel change applies after running conversion
// RL8 - trigger edge resets divider, starts conversion
// RL9 - edges during conversion ignored, levels ignored
// RL10 - trigger flag must fall before next trigger
// RL11 - done-flag source restarts after each conversion
// RL12 - start flag works with auto trigger
// RL13 - divider held reset while converter disabled
// RL14 - divider ratio chosen by prescale select
// RL15 - software keeps converter clock in range
// RL16 - software start waits for converter clock edge
// RL17 - 13 cycles normal, 25 cycles first
// RL18 - sample at 1.5 or 13.5 cycles
// RL19 - completion writes result, sets done, clears start
// RL20 - auto trigger: sample 2, total 13.5
// RL21 - free running: sample 2.5, total 14
// RL22 - channel and reference routed to converter
// RL23 - selections locked during conversion until last cycle
// RL24 - sleep halt starts idle single conversion
// RL25 - each trigger a separate input, edge-detected
module acs_sequencer
   import acs_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] trig_in,
   input wire logic sleep_halt,
   input wire logic [9:0] sar_result,
   output logic ana_enable,
   output logic [3:0] ana_channel,
   output logic ana_reference,
   output logic sample_hold,
   output logic done_irq
);
   import acs_pkg::*;

   acs_regs_t s_r;
   acs_regs_t s_nxt;
   logic [6:0] mask;
   logic tick;
   logic half;
   logic [7:0] edge_vec;
   logic sel_edge;
   logic sw_start;
   logic sleep_start;
   logic [5:0] ph_inc;
   logic finish;
   logic rd_take;
   logic last_cycle;

   // all checks below share this clock and reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
   assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = !s_r.rvalid;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign ana_enable = s_r.en;
   assign ana_channel = s_r.en ? s_r.chan_lk : 4'h0;  // RL1 RL22
   assign ana_reference = s_r.en & s_r.ref_lk;  // RL1 RL22
   assign sample_hold = s_r.sh_pulse;
   assign done_irq = s_r.done_flag & s_r.irq_en;

   always_comb begin
      s_nxt = s_r;
      s_nxt.sh_pulse = 1'b0;
      finish = 1'b0;
      sw_start = 1'b0;
      rd_take = s_axi_arvalid && !s_r.rvalid;
      mask = div_mask(s_r.presc);  // RL14
      tick = s_r.en && ((s_r.div & mask) == mask);
      half = s_r.en && ((s_r.div & mask) == (mask >> 1));
      ph_inc = s_r.ph + 6'h01;
      last_cycle = (s_r.ph >= (len_x2(s_r.kind) - LAST_CYCLE_X2));
      // rising edges of separate trigger inputs
      edge_vec = trig_in & ~s_r.trig_q;  // RL25
      s_nxt.trig_q = trig_in;
      // a held-high flag gives no new edge until software clears it
      sel_edge = s_r.auto_en && (s_r.trig_sel != TRIG_DONE_FLAG)
         && edge_vec[s_r.trig_sel];  // RL8 RL10
      sleep_start = sleep_halt && !s_r.sleep_q && !s_r.auto_en;  // RL24
      s_nxt.sleep_q = sleep_halt;
      s_nxt.div = s_r.en ? s_r.div + 7'h01 : 7'h00;  // RL13

      // write channel
      if (s_axi_awvalid && s_axi_awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = s_axi_wdata[7:0];
         s_nxt.w_lane = s_axi_wstrb[0];
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         unique case (s_r.aw_addr)
            ADDR_CTRL_A: begin
               if (s_r.w_lane) begin
                  s_nxt.en = s_r.w_data[CA_ENABLE];
                  s_nxt.auto_en = s_r.w_data[CA_AUTO];
                  s_nxt.irq_en = s_r.w_data[CA_IRQ_EN];
                  s_nxt.presc = s_r.w_data[CA_PRESC_LSB +: 3];
                  sw_start = s_r.w_data[CA_START];  // RL6 RL12
                  if (s_r.w_data[CA_DONE]) begin
                     s_nxt.done_flag = 1'b0;
                  end
               end
            end
            ADDR_CTRL_B: begin
               if (s_r.w_lane) begin
                  s_nxt.left = s_r.w_data[CB_LEFT];
                  s_nxt.trig_sel = s_r.w_data[CB_TRIG_LSB +: 3];
               end
            end
            ADDR_CH_REF: begin
               if (s_r.w_lane) begin
                  s_nxt.ref_sw = s_r.w_data[CR_REF];
                  s_nxt.chan_sw = s_r.w_data[CR_CHAN_LSB +: 4];
               end
            end
            ADDR_RES_LO, ADDR_RES_HI: begin
            end
            default: s_nxt.bresp = RESP_SLVERR;
         endcase
      end

      // read channel
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (rd_take) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = RESP_OKAY;
         s_nxt.rdata = RDATA_RESET;
         unique case (s_axi_araddr)
            ADDR_CTRL_A: begin
               s_nxt.rdata[CA_ENABLE] = s_r.en;
               s_nxt.rdata[CA_START] = (s_r.st != ST_IDLE);  // RL12
               s_nxt.rdata[CA_AUTO] = s_r.auto_en;
               s_nxt.rdata[CA_DONE] = s_r.done_flag;
               s_nxt.rdata[CA_IRQ_EN] = s_r.irq_en;
               s_nxt.rdata[CA_PRESC_LSB +: 3] = s_r.presc;
            end
            ADDR_CTRL_B: begin
               s_nxt.rdata[CB_LEFT] = s_r.left;
               s_nxt.rdata[CB_TRIG_LSB +: 3] = s_r.trig_sel;
            end
            ADDR_CH_REF: begin
               s_nxt.rdata[CR_REF] = s_r.ref_sw;
               s_nxt.rdata[CR_CHAN_LSB +: 4] = s_r.chan_sw;
            end
            ADDR_RES_LO: begin
               s_nxt.rdata[7:0] = s_r.res_lo;
               s_nxt.rd_lock = 1'b1;  // RL3
            end
            ADDR_RES_HI: begin
               s_nxt.rdata[7:0] = s_r.res_hi;
               s_nxt.rd_lock = 1'b0;  // RL4
            end
            default: s_nxt.rresp = RESP_SLVERR;
         endcase
      end

      // selections follow software except before the last cycle of a running conversion
      if (s_r.st != ST_RUN || last_cycle) begin
         s_nxt.chan_lk = s_r.chan_sw;  // RL7 RL23
         s_nxt.ref_lk = s_r.ref_sw;  // RL23
      end

      // conversion sequencer
      unique case (s_r.st)
         ST_IDLE: begin
            if (sw_start || sleep_start) begin
               s_nxt.st = ST_PEND;  // RL6 RL24
            end else if (sel_edge) begin
               s_nxt.st = ST_SYNC;  // RL8
               s_nxt.sync = 2'h0;
            end
         end
         ST_PEND: begin
            if (tick) begin
               s_nxt.st = ST_RUN;  // RL16
               s_nxt.ph = 6'h00;
               s_nxt.kind = s_r.first ? KIND_FIRST : KIND_NORM;  // RL17
            end
         end
         ST_SYNC: begin
            s_nxt.sync = s_r.sync + 2'h1;
            if (s_r.sync == SYNC_CYCLES - 2'h1) begin
               s_nxt.st = ST_RUN;  // RL20
               s_nxt.ph = 6'h00;
               s_nxt.div = 7'h00;  // RL8
               s_nxt.kind = s_r.first ? KIND_FIRST : KIND_AUTO;
            end
         end
         ST_RUN: begin
            // trigger edges are not looked at here
            if (tick || half) begin  // RL9
               s_nxt.ph = ph_inc;
               if (ph_inc == sh_x2(s_r.kind)) begin
                  s_nxt.sh_pulse = 1'b1;  // RL18 RL20 RL21
               end
               if (ph_inc == len_x2(s_r.kind)) begin
                  finish = 1'b1;  // RL17
               end
            end
         end
      endcase

      if (finish) begin
         s_nxt.done_flag = 1'b1;  // RL5 RL19
         s_nxt.first = 1'b0;
         if (!s_r.rd_lock) begin  // RL3
            if (s_r.left) begin
               s_nxt.res_hi = sar_result[9:2];  // RL2
               s_nxt.res_lo = {sar_result[1:0], 6'h00};
            end else begin
               s_nxt.res_hi = {6'h00, sar_result[9:8]};  // RL2
               s_nxt.res_lo = sar_result[7:0];
            end
         end
         if (s_r.auto_en && s_r.trig_sel == TRIG_DONE_FLAG) begin
            s_nxt.ph = 6'h00;  // RL11 RL21
            s_nxt.kind = KIND_FREE;
         end else begin
            s_nxt.st = ST_IDLE;  // RL19
         end
      end

      if (!s_r.en) begin
         s_nxt.st = ST_IDLE;
         s_nxt.first = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
         s_r.first <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // completion: flag, result bytes, next state
   a_done_sets_flag: assert property ( // RL19
      ce && finish |=> s_r.done_flag)
      else $error("done flag not set at completion");
   a_lock_holds_bytes: assert property ( // RL3
      ce && finish && s_r.rd_lock
      |=> $stable(s_r.res_lo) && $stable(s_r.res_hi))
      else $error("blocked result bytes were updated");
   a_lost_still_flags: assert property ( // RL5
      ce && finish && s_r.rd_lock |=> s_r.done_flag)
      else $error("done flag missing for discarded result");
   a_right_align: assert property ( // RL2
      ce && finish && !s_r.rd_lock && !s_r.left
      |=> s_r.res_hi[7:2] == 6'h00)
      else $error("right-aligned high byte has stray bits");
   a_left_align: assert property ( // RL2
      ce && finish && !s_r.rd_lock && s_r.left
      |=> s_r.res_lo[5:0] == 6'h00)
      else $error("left-aligned low byte has stray bits");
   a_single_clears: assert property ( // RL19
      ce && finish && !s_r.auto_en && s_r.en
      |=> s_r.st == ST_IDLE)
      else $error("start flag not cleared after single conversion");
   a_free_continues: assert property ( // RL11 RL21
      ce && finish && s_r.en && s_r.auto_en
      && s_r.trig_sel == TRIG_DONE_FLAG
      |=> s_r.st == ST_RUN && s_r.kind == KIND_FREE)
      else $error("free-running conversion did not restart");
   a_sh_one_cycle: assert property ( // RL18
      ce && s_r.sh_pulse |=> !s_r.sh_pulse)
      else $error("sample pulse longer than one cycle");

   // result byte lock and status read
   a_low_read_locks: assert property ( // RL3
      ce && rd_take && s_axi_araddr == ADDR_RES_LO |=> s_r.rd_lock)
      else $error("low byte read did not block updates");
   a_high_read_unlocks: assert property ( // RL4
      ce && rd_take && s_axi_araddr == ADDR_RES_HI |=> !s_r.rd_lock)
      else $error("high byte read left update block set");
   a_start_reads_busy: assert property ( // RL12
      ce && rd_take && s_axi_araddr == ADDR_CTRL_A && s_r.st != ST_IDLE
      |=> s_r.rdata[CA_START])
      else $error("start flag read low during conversion");

   // divider and enable
   a_div_held_off: assert property ( // RL13
      ce && !s_r.en ##1 ce |=> s_r.div == 7'h00 || s_r.en)
      else $error("divider counted while disabled");
   a_off_first: assert property ( // RL13 RL17
      ce && !s_r.en |=> s_r.first && s_r.st == ST_IDLE)
      else $error("disable did not abort or rearm first conversion");
   a_off_no_select: assert property ( // RL1
      !s_r.en |-> ana_channel == 4'h0 && !ana_reference)
      else $error("selection applied while disabled");

   // start sequencing
   a_pend_waits: assert property ( // RL16
      ce && s_r.en && s_r.st == ST_PEND && !tick |=> s_r.st == ST_PEND)
      else $error("software start ran before converter clock edge");
   a_pend_starts: assert property ( // RL16
      ce && s_r.en && s_r.st == ST_PEND && tick
      |=> s_r.st == ST_RUN && s_r.ph == 6'h00)
      else $error("software start missed converter clock edge");
   a_run_ignores_edge: assert property ( // RL9
      ce && s_r.en && s_r.st == ST_RUN && sel_edge && !finish
      |=> s_r.st == ST_RUN)
      else $error("trigger edge disturbed running conversion");
   a_idle_no_level: assert property ( // RL9
      ce && s_r.st == ST_IDLE && !sel_edge && !sw_start && !sleep_start
      |=> s_r.st == ST_IDLE)
      else $error("conversion started without a start event");
   a_chan_locked: assert property ( // RL23
      ce && s_r.st == ST_RUN && !last_cycle && !finish
      |=> $stable(s_r.chan_lk))
      else $error("channel changed during conversion");
   a_sync_to_run: assert property ( // RL20
      ce && s_r.en && s_r.st == ST_SYNC
      |=> s_r.st inside {ST_SYNC, ST_RUN})
      else $error("synchronisation left for a wrong state");
   a_sync_delay: assert property ( // RL20
      s_r.st == ST_IDLE && sel_edge && !sw_start && !sleep_start && ce
      && s_r.en ##1 ce [*3] |=> s_r.st == ST_RUN && s_r.div == 7'h00
      || !s_r.en)
      else $error("auto trigger start not after three cycles");

   // main scenarios
   c_first_done: cover property (finish && s_r.kind == KIND_FIRST);
   c_free_run: cover property (finish && s_r.kind == KIND_FREE);
   c_lost_result: cover property (finish && s_r.rd_lock);
   c_auto_start: cover property (s_r.st == ST_SYNC);
   c_sleep_start: cover property (sleep_start && s_r.st == ST_IDLE);

endmodule : acs_sequencer

// >>> tb/acs_sar_model.sv
module acs_sar_model (
   input wire logic clk,
   input wire logic ana_enable,
   input wire logic [3:0] ana_channel,
   input wire logic sample_hold,
   output logic [9:0] sar_result
);
   timeunit 1ns;
   timeprecision 1ns;

   initial sar_result = 10'h155;

   // code is tied to the held channel so results show which input was used
   always @(posedge clk) begin
      if (!ana_enable) begin
         sar_result <= ~sar_result;
      end else if (sample_hold) begin
         sar_result <= {ana_channel, 6'h2A};
      end
   end
endmodule : acs_sar_model

// >>> tb/acs_sequencer_tb.sv
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
$display("ERROR %0t got %0h exp %0h", $time, (a), (e)); end end

module acs_sequencer_tb
   import acs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk = 1'b0;
   logic rstn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, sleep_halt;
   logic ana_enable, ana_reference, sample_hold, done_irq;
   logic [7:0] awaddr, araddr, trig_in;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, ana_channel;
   logic [1:0] bresp, rresp;
   logic [9:0] sar_result;
   int failures = 0;
   int comparisons = 0;
   int cyc = 0;
   int shc = 0;
   int base;
   int n;

   always #25 clk = ~clk;

   acs_sequencer i_acs_sequencer (.clk(clk), .rstn(rstn), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .trig_in(trig_in), .sleep_halt(sleep_halt),
      .sar_result(sar_result), .ana_enable(ana_enable),
      .ana_channel(ana_channel), .ana_reference(ana_reference),
      .sample_hold(sample_hold), .done_irq(done_irq));

   acs_sar_model i_acs_sar_model (.clk(clk), .ana_enable(ana_enable),
      .ana_channel(ana_channel), .sample_hold(sample_hold),
      .sar_result(sar_result));

   task automatic stop_test();
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   always @(posedge clk) begin
      cyc++;
      if (sample_hold) shc++;
      if (cyc == 60000) begin
         failures++;
         stop_test();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      `CHK(bresp, RESP_OKAY)
      bready <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      `CHK(rresp, er)
      if (er == RESP_OKAY) `CHK(rdata, e)
      rready <= 1'b0;
      @(posedge clk);
   endtask : rd

   // cycles until the sample pulse, then until the done request
   task automatic wsh(output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (!sample_hold && k < 4000);
   endtask : wsh

   task automatic wdn(output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (!done_irq && k < 4000);
   endtask : wdn

   // single start with done cleared, divider at 128
   task automatic cnv();
      int k;
      wr(ADDR_CTRL_A, 32'hDF);
      wsh(k);
      `CHK(k < 400, 1'b1)
      wdn(k);
      `CHK(k, 1472)
   endtask : cnv

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, sleep_halt} = 6'h00;
      {awaddr, araddr, trig_in, wstrb} = 28'h0;
      wdata = 32'h0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd(ADDR_CTRL_A, 32'h0, RESP_OKAY);
      rd(8'h14, 32'h0, RESP_SLVERR);
      wr(ADDR_CH_REF, 32'h45);
      `CHK(ana_channel, 4'h0)
      wr(ADDR_CTRL_A, 32'h8F);
      `CHK({ana_enable, ana_reference, ana_channel}, 6'h35)
      wr(ADDR_CTRL_A, 32'hCF);
      rd(ADDR_CTRL_A, 32'hCF, RESP_OKAY);
      repeat (130) @(posedge clk);
      wr(ADDR_CH_REF, 32'h03);
      `CHK(ana_channel, 4'h5)
      wsh(n);
      `CHK(n > 1500, 1'b1)
      wdn(n);
      `CHK(n, 1472)
      `CHK(ana_channel, 4'h3)
      rd(ADDR_CTRL_A, 32'h9F, RESP_OKAY);
      rd(ADDR_RES_LO, 32'h6A, RESP_OKAY);
      rd(ADDR_RES_HI, 32'h01, RESP_OKAY);
      rd(ADDR_RES_LO, 32'h6A, RESP_OKAY);
      cnv();
      `CHK(done_irq, 1'b1)
      rd(ADDR_RES_HI, 32'h01, RESP_OKAY);
      cnv();
      rd(ADDR_RES_LO, 32'hEA, RESP_OKAY);
      rd(ADDR_RES_HI, 32'h00, RESP_OKAY);
      wr(ADDR_CTRL_B, 32'h10);
      cnv();
      rd(ADDR_RES_LO, 32'h80, RESP_OKAY);
      rd(ADDR_RES_HI, 32'h3A, RESP_OKAY);
      wr(ADDR_CTRL_A, 32'hFF);
      wsh(n);
      wsh(n);
      `CHK(n, 1792)
      wsh(n);
      `CHK(n, 1792)
      rd(ADDR_CTRL_A, 32'hFF, RESP_OKAY);
      wr(ADDR_CTRL_A, 32'h9F);
      repeat (2000) @(posedge clk);
      wr(ADDR_CTRL_B, 32'h11);
      wr(ADDR_CTRL_A, 32'hBF);
      base = shc;
      trig_in <= 8'h02;
      wsh(n);
      `CHK(n >= 256 && n <= 266, 1'b1)
      rd(ADDR_CTRL_A, 32'hEF, RESP_OKAY);
      trig_in <= 8'h00;
      @(posedge clk);
      trig_in <= 8'h02;
      wdn(n);
      `CHK(n < 1472, 1'b1)
      repeat (3000) @(posedge clk);
      `CHK(shc, base + 1)
      trig_in <= 8'h00;
      wr(ADDR_CTRL_A, 32'h9F);
      sleep_halt <= 1'b1;
      wsh(n);
      `CHK(n < 400, 1'b1)
      wdn(n);
      sleep_halt <= 1'b0;
      wr(ADDR_CTRL_A, 32'h00);
      `CHK({ana_enable, ana_channel}, 5'h00)
      wr(ADDR_CTRL_A, 32'h8F);
      wr(ADDR_CTRL_A, 32'hCF);
      wsh(n);
      `CHK(n > 1500, 1'b1)
      wdn(n);
      stop_test();
   end
endmodule : acs_sequencer_tb
